// ### bench/ldx_core_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// load group timing and side-effect checks
// ----------------------------------------
module ldx_core_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic START,
    input wire ldx_pkg::ldx_instr_t INSTR,
    input wire logic FLAG_WE,
    input wire logic [7:0] FLAG_WDATA,
    input wire ldx_pkg::ldx_mem_t MEM_REQ,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic ILLEGAL,
    input wire logic [7:0] FLAGS
);
    // expected length per opcode, 1 marks a code outside the group
    function automatic logic [4:0] cyc_of(input logic [7:0] op);
        case (op)
            8'hc7, 8'hd7: cyc_of = 5'h04;
            8'he4, 8'he5, 8'he6, 8'hd6, 8'hf5, 8'h87, 8'h97, 8'h47: cyc_of = 5'h06;
            8'hc3, 8'hd3: cyc_of = 5'h0a;
            8'he7, 8'hf7: cyc_of = 5'h0c;
            8'ha7, 8'hb7: cyc_of = 5'h0e;
            default: cyc_of = (op[3:0] inside {4'hc, 4'h8, 4'h9}) ? 5'h04 : 5'h01;
        endcase
    endfunction : cyc_of

    logic take; // instruction accepted this edge
    logic [4:0] cnt_r, cnt_nxt; // enabled edges since acceptance
    logic [4:0] exp_r, exp_nxt; // length owed by the running instruction
    assign take = CE && START && !BUSY;

    // counter follows CE so stretched runs are not flagged
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = exp_r;
        if (take) begin
            cnt_nxt = 5'h00;
            exp_nxt = cyc_of(INSTR.op);
        end else if (BUSY && CE) begin
            cnt_nxt = cnt_r + 5'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_r <= 5'h00;
            exp_r <= 5'h00;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------------------------------------
    // memory request sequences
    // ----------------------------------------
    sequence s_take_ld;
        take && INSTR.op inside {8'hc3, 8'he7, 8'ha7};
    endsequence
    sequence s_take_st;
        take && INSTR.op inside {8'hd3, 8'hf7, 8'hb7};
    endsequence

    a_done_count: assert property (DONE |-> cnt_r == exp_r)
        else $error("done after wrong cycle count");
    a_busy_bound: assert property (BUSY |-> cnt_r < exp_r)
        else $error("busy past instruction length");
    a_take_busy: assert property (take && cyc_of(INSTR.op) != 5'h01 |=> BUSY && !DONE)
        else $error("accepted instruction not busy");
    // the no-op spends one execute edge, so done and the flag show two edges after acceptance
    a_take_bad: assert property (take && cyc_of(INSTR.op) == 5'h01 |-> ##2 ILLEGAL && DONE)
        else $error("unknown opcode not flagged");
    a_load_req: assert property (s_take_ld ##1 CE |=> MEM_REQ.rd && !MEM_REQ.wr
        && MEM_REQ.space == $past(INSTR.b1[0], 2))
        else $error("memory read request wrong");
    a_store_req: assert property (s_take_st ##1 CE |=> MEM_REQ.wr && !MEM_REQ.rd
        && MEM_REQ.space == $past(INSTR.b1[0], 2))
        else $error("memory write request wrong");
    a_rd_pulse: assert property (MEM_REQ.rd && CE |=> !MEM_REQ.rd)
        else $error("read strobe longer than one cycle");
    a_flags_hold: assert property (!FLAG_WE && CE |=> FLAGS == $past(FLAGS))
        else $error("flags changed by load group");
    a_flag_write: assert property (FLAG_WE && CE |=> FLAGS == $past(FLAG_WDATA))
        else $error("flag write lost");
endmodule : ldx_core_chk

bind ldx_core ldx_core_chk i_chk (
    .CLK(CLK), .RST(RST), .CE(CE), .START(START), .INSTR(INSTR), .FLAG_WE(FLAG_WE),
    .FLAG_WDATA(FLAG_WDATA), .MEM_REQ(MEM_REQ), .BUSY(BUSY), .DONE(DONE),
    .ILLEGAL(ILLEGAL), .FLAGS(FLAGS)
);

// ### bench/test_load_instruction_decode.sv
`timescale 1ns/1ns
module test_load_instruction_decode;
    logic CLK, RST, CE, START, FLAG_WE, REG_WE, BUSY, DONE, ILLEGAL, ill;
    ldx_pkg::ldx_instr_t INSTR;
    ldx_pkg::ldx_mem_t MEM_REQ, req; // req: request seen after first edge
    logic [3:0] WORK_BASE;
    logic [7:0] MEM_RDATA, FLAG_WDATA, REG_WADDR, REG_WDATA, DBG_ADDR, FLAGS, DBG_DATA;
    int error_cnt = 0;
    int samples_checked = 0;
    int k; // cycles counted up to done

    ldx_core i_dut (.CLK(CLK), .RST(RST), .CE(CE), .START(START), .INSTR(INSTR),
        .WORK_BASE(WORK_BASE), .MEM_RDATA(MEM_RDATA), .FLAG_WE(FLAG_WE), .FLAG_WDATA(FLAG_WDATA),
        .REG_WE(REG_WE), .REG_WADDR(REG_WADDR), .REG_WDATA(REG_WDATA), .DBG_ADDR(DBG_ADDR),
        .MEM_REQ(MEM_REQ), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL), .FLAGS(FLAGS),
        .DBG_DATA(DBG_DATA));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // one instruction; memory data held until done, then scrambled
    task automatic run(input logic [31:0] ins, input logic [7:0] n, input logic [7:0] rd);
        @(negedge CLK);
        INSTR = ins;
        START = 1'b1;
        MEM_RDATA = rd;
        @(negedge CLK);
        START = 1'b0;
        k = 0;
        while (DONE !== 1'b1 && k < 40) begin
            @(negedge CLK);
            k++;
            if (k == 1) req = MEM_REQ;
        end
        ill = ILLEGAL;
        MEM_RDATA = ~rd;
        check("cycles", k, n);
        check("flags", FLAGS, 8'ha5);
        check("illegal", ill, n == 8'h01);
    endtask : run

    // register file peek, data one edge after address
    task automatic peek(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CLK);
        DBG_ADDR = a;
        @(negedge CLK);
        check("reg", DBG_DATA, exp);
    endtask : peek

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset in mid-instruction must cancel it
    task automatic t_reset;
        logic [15:0] pre [9] = '{16'h4077, 16'h1140, 16'h12f0, 16'h2050, 16'h1099, 16'h3005,
            16'h1806, 16'h1c01, 16'h1d04};
        // flags set first, so the first move already holds them
        @(negedge CLK);
        FLAG_WE = 1'b1;
        FLAG_WDATA = 8'ha5;
        @(negedge CLK);
        FLAG_WE = 1'b0;
        run(32'h00aa40e6, 8'h06, 8'h00);
        // a different value, so a write that slips through shows
        @(negedge CLK);
        INSTR = 32'h005540e6;
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
        RST = 1'b1;
        @(negedge CLK);
        RST = 1'b0;
        check("busy", BUSY, 1'b0);
        check("flags", FLAGS, 8'h00);
        repeat (8) begin
            @(negedge CLK);
            check("done", DONE, 1'b0);
        end
        peek(8'h40, 8'haa);
        FLAG_WE = 1'b1;
        FLAG_WDATA = 8'ha5;
        foreach (pre[i]) begin
            @(negedge CLK);
            FLAG_WE = 1'b0;
            REG_WE = 1'b1;
            {REG_WADDR, REG_WDATA} = pre[i];
        end
        @(negedge CLK);
        REG_WE = 1'b0;
    endtask : t_reset

    // every move form, ending on indexed wrap
    task automatic t_moves;
        logic [55:0] tbl [12] = '{{32'h5a3c, 8'h4, 16'h135a}, {32'h4048, 8'h4, 16'h1477},
            {32'h4239, 8'h4, 16'h425a}, {32'h4342e4, 8'h6, 16'h435a}, {32'h4411e5, 8'h6, 16'h4477},
            {32'hc345e6, 8'h6, 16'h45c3}, {32'h3e20d6, 8'h6, 16'h503e}, {32'h2045f5, 8'h6, 16'h50c3},
            {32'h61c7, 8'h4, 16'h1677}, {32'h13d7, 8'h4, 16'h405a}, {32'h207287, 8'h6, 16'h1799},
            {32'h553297, 8'h6, 16'h455a}};
        foreach (tbl[i]) begin
            run(tbl[i][55:24], tbl[i][23:16], 8'h00);
            peek(tbl[i][15:8], tbl[i][7:0]);
        end
        peek(8'h42, 8'h5a);
    endtask : t_moves

    // bit load then bit store, neighbours untouched
    task automatic t_bits;
        run(32'h308447, 8'h6, 8'h00);
        peek(8'h18, 8'h07);
        peek(8'h30, 8'h05);
        run(32'h308f47, 8'h6, 8'h00);
        peek(8'h30, 8'h85);
        peek(8'h18, 8'h07);
    endtask : t_bits

    // memory forms in both spaces and directions
    task automatic t_mem;
        logic [57:0] e;
        logic [57:0] m [11] = '{{32'hacc3, 8'ha, 16'h0104, 2'b00}, {32'hadc3, 8'ha, 16'h0104, 2'b01},
            {32'h3cd3, 8'ha, 16'h0104, 2'b10}, {32'h3dd3, 8'ha, 16'h0104, 2'b11},
            {32'h01ace7, 8'hc, 16'h0105, 2'b00}, {32'hff3df7, 8'hc, 16'h0203, 2'b11},
            {32'h1000aca7, 8'he, 16'h1104, 2'b00}, {32'h1104a0a7, 8'he, 16'h1104, 2'b00},
            {32'h1105a1a7, 8'he, 16'h1105, 2'b01}, {32'hffff3cb7, 8'he, 16'h0103, 2'b10},
            {32'h110531b7, 8'he, 16'h1105, 2'b11}};
        foreach (m[i]) begin
            e = m[i];
            run(e[57:26], e[25:18], e[9:2] ^ 8'h3c);
            check("rd", req.rd, !e[1]);
            check("wr", req.wr, e[1]);
            check("addr", req.addr, e[17:2]);
            check("space", req.space, e[0]);
            if (e[1]) check("wdata", req.wdata, 8'h5a);
            else peek(8'h1a, e[9:2] ^ 8'h3c);
        end
        peek(8'h1c, 8'h01);
    endtask : t_mem

    // clock enable low freezes the sequencer, stretching the count
    task automatic t_stall;
        @(negedge CLK);
        INSTR = 32'h00664be6;
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
        CE = 1'b0;
        repeat (3) @(negedge CLK);
        check("frozen", BUSY, 1'b1);
        CE = 1'b1;
        repeat (6) @(negedge CLK);
        check("stretch", DONE, 1'b1);
        peek(8'h4b, 8'h66);
    endtask : t_stall

    // code outside the group is a flagged no-op
    task automatic t_illegal;
        run(32'h00, 8'h1, 8'h00);
        check("illegal", ill, 1'b1);
    endtask : t_illegal

    initial begin
        RST = 1'b1;
        CE = 1'b1;
        START = 1'b0;
        INSTR = '0;
        WORK_BASE = 4'h1;
        MEM_RDATA = 8'h00;
        FLAG_WE = 1'b0;
        FLAG_WDATA = 8'h00;
        REG_WE = 1'b0;
        REG_WADDR = 8'h00;
        REG_WDATA = 8'h00;
        DBG_ADDR = 8'h00;
        repeat (5) @(negedge CLK);
        RST = 1'b0;
        t_reset;
        t_moves;
        t_bits;
        t_mem;
        t_stall;
        t_illegal;
        tally_and_finish;
    end

    // hang guard, well beyond the expected run
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish;
    end
endmodule : test_load_instruction_decode

// ### rtl/ldx_core.sv
`timescale 1ns/1ns
`include "ldx_map.svh"
module ldx_core (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic START,
    input wire ldx_pkg::ldx_instr_t INSTR,
    input wire logic [3:0] WORK_BASE,
    input wire logic [7:0] MEM_RDATA,
    input wire logic FLAG_WE,
    input wire logic [7:0] FLAG_WDATA,
    input wire logic REG_WE,
    input wire logic [7:0] REG_WADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] DBG_ADDR,
    output ldx_pkg::ldx_mem_t MEM_REQ,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL,
    output logic [7:0] FLAGS,
    output logic [7:0] DBG_DATA
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] rf [0:255]; // register file, not reset
    ldx_pkg::ldx_state_t state_r, state_nxt;
    ldx_pkg::ldx_instr_t ins_r, ins_nxt; // latched instruction
    ldx_pkg::ldx_mem_t mem_r, mem_nxt;
    logic [3:0] cnt_r, cnt_nxt; // cycles left
    logic first_r, first_nxt; // first execute cycle
    logic ld_r, ld_nxt; // memory load pending
    logic [7:0] lda_r, lda_nxt; // its destination register
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic bad_r, bad_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] dbg_r;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // working register n sits in the current 16-byte bank
    function automatic logic [7:0] wa(input logic [3:0] n);
        wa = {WORK_BASE, n};
    endfunction : wa

    // cycle count per opcode, unknown codes finish after one execute cycle
    function automatic logic [3:0] cyc_of(input logic [7:0] op);
        case (op)
            `LDX_OP_IR_LD, `LDX_OP_IR_ST: cyc_of = `LDX_CYC_SHORT;
            `LDX_OP_RR, `LDX_OP_R_IR, `LDX_OP_R_IM, `LDX_OP_IR_IM,
            `LDX_OP_IR_R, `LDX_OP_X_LD, `LDX_OP_X_ST: cyc_of = `LDX_CYC_LONG;
            `LDX_OP_BIT: cyc_of = `LDX_CYC_LONG;
            `LDX_OP_MP_LD, `LDX_OP_MP_ST: cyc_of = `LDX_CYC_MEM_PTR;
            `LDX_OP_XS_LD, `LDX_OP_XS_ST: cyc_of = `LDX_CYC_MEM_XS;
            `LDX_OP_XL_LD, `LDX_OP_XL_ST: cyc_of = `LDX_CYC_MEM_XL;
            default: begin
                // nibble-coded working register forms
                if (op[3:0] == `LDX_LO_IMM || op[3:0] == `LDX_LO_LDR || op[3:0] == `LDX_LO_STR) begin
                    cyc_of = `LDX_CYC_SHORT;
                end else begin
                    cyc_of = `LDX_CYC_BAD;
                end
            end
        endcase
    endfunction : cyc_of

    // ----------------------------------------
    // execute: operand fetch and result select
    // ----------------------------------------
    logic x_we; // register write on first cycle
    logic [7:0] x_wa;
    logic [7:0] x_wd;
    logic x_mem; // memory access on first cycle
    logic x_ld; // memory access is a load
    logic [15:0] x_ma;
    logic x_bad;
    logic [7:0] hw, b1h, b1l; // working register addresses
    logic [3:0] pr; // register pair field
    logic [15:0] rr_val; // pair contents, even half high
    logic [7:0] bitv; // bit transfer merge value

    // one write port suffices: every move writes one byte
    always_comb begin
        hw = wa(ins_r.op[7:4]);
        b1h = wa(ins_r.b1[7:4]);
        b1l = wa(ins_r.b1[3:0]);
        pr = ins_r.b1[3:0];
        rr_val = {rf[wa({pr[3:1], 1'b0})], rf[wa({pr[3:1], 1'b1})]};
        bitv = 8'h00;
        x_we = 1'b0;
        x_wa = 8'h00;
        x_wd = 8'h00;
        x_mem = 1'b0;
        x_ld = 1'b0;
        x_ma = 16'h0000;
        x_bad = 1'b0;
        // source operands are only read, never written back
        case (ins_r.op)
            `LDX_OP_IR_LD: begin
                x_we = 1'b1;
                x_wa = b1h;
                x_wd = rf[rf[b1l]];
            end
            `LDX_OP_IR_ST: begin
                x_we = 1'b1;
                x_wa = rf[b1h];
                x_wd = rf[b1l];
            end
            `LDX_OP_RR: begin
                x_we = 1'b1;
                x_wa = ins_r.b2;
                x_wd = rf[ins_r.b1];
            end
            `LDX_OP_R_IR: begin
                x_we = 1'b1;
                x_wa = ins_r.b2;
                x_wd = rf[rf[ins_r.b1]];
            end
            `LDX_OP_R_IM: begin
                x_we = 1'b1;
                x_wa = ins_r.b1;
                x_wd = ins_r.b2;
            end
            `LDX_OP_IR_IM: begin
                x_we = 1'b1;
                x_wa = rf[ins_r.b1];
                x_wd = ins_r.b2;
            end
            `LDX_OP_IR_R: begin
                x_we = 1'b1;
                x_wa = rf[ins_r.b2];
                x_wd = rf[ins_r.b1];
            end
            `LDX_OP_X_LD: begin
                x_we = 1'b1;
                x_wa = b1h;
                x_wd = rf[8'(ins_r.b2 + rf[b1l])];
            end
            `LDX_OP_X_ST: begin
                x_we = 1'b1;
                x_wa = 8'(ins_r.b2 + rf[b1l]);
                x_wd = rf[b1h];
            end
            `LDX_OP_BIT: begin
                x_we = 1'b1;
                if (ins_r.b1[0]) begin
                    // store: working bit 0 into general register bit b
                    bitv = rf[ins_r.b2];
                    bitv[ins_r.b1[3:1]] = rf[b1h][0];
                    x_wa = ins_r.b2;
                end else begin
                    // load: general bit b into working bit 0
                    bitv = {rf[b1h][7:1], rf[ins_r.b2][ins_r.b1[3:1]]};
                    x_wa = b1h;
                end
                x_wd = bitv;
            end
            `LDX_OP_MP_LD, `LDX_OP_MP_ST: begin
                x_mem = 1'b1;
                x_ld = (ins_r.op == `LDX_OP_MP_LD);
                x_ma = rr_val;
            end
            `LDX_OP_XS_LD, `LDX_OP_XS_ST: begin
                x_mem = 1'b1;
                x_ld = (ins_r.op == `LDX_OP_XS_LD);
                x_ma = 16'(rr_val + {8'h00, ins_r.b2});
            end
            `LDX_OP_XL_LD, `LDX_OP_XL_ST: begin
                x_mem = 1'b1;
                x_ld = (ins_r.op == `LDX_OP_XL_LD);
                // fields 0 and 1 mean direct address, never index pair 0-1
                if (pr == `LDX_PAIR_DA_PROG || pr == `LDX_PAIR_DA_DATA) begin
                    x_ma = {ins_r.b3, ins_r.b2};
                end else begin
                    x_ma = 16'(rr_val + {ins_r.b3, ins_r.b2});
                end
            end
            default: begin
                if (ins_r.op[3:0] == `LDX_LO_IMM) begin
                    x_we = 1'b1;
                    x_wa = hw;
                    x_wd = ins_r.b1;
                end else if (ins_r.op[3:0] == `LDX_LO_LDR) begin
                    x_we = 1'b1;
                    x_wa = hw;
                    x_wd = rf[ins_r.b1];
                end else if (ins_r.op[3:0] == `LDX_LO_STR) begin
                    x_we = 1'b1;
                    x_wa = ins_r.b1;
                    x_wd = rf[hw];
                end else begin
                    x_bad = 1'b1; // not a load group opcode: no effect
                end
            end
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // fixed cycle counts: a load samples MEM_RDATA on the last cycle
    always_comb begin
        state_nxt = state_r;
        ins_nxt = ins_r;
        cnt_nxt = cnt_r;
        first_nxt = 1'b0;
        ld_nxt = ld_r;
        lda_nxt = lda_r;
        done_nxt = 1'b0;
        bad_nxt = 1'b0;
        mem_nxt = mem_r;
        mem_nxt.rd = 1'b0; // strobes last one cycle
        mem_nxt.wr = 1'b0;
        // flags belong to other units; load group never writes them
        flags_nxt = FLAG_WE ? FLAG_WDATA : flags_r;
        unique case (state_r)
            ldx_pkg::LDX_IDLE: begin
                if (START) begin
                    ins_nxt = INSTR;
                    cnt_nxt = cyc_of(INSTR.op);
                    first_nxt = 1'b1;
                    state_nxt = ldx_pkg::LDX_EXEC;
                end
            end
            ldx_pkg::LDX_EXEC: begin
                if (first_r && x_mem) begin
                    mem_nxt.rd = x_ld;
                    mem_nxt.wr = !x_ld;
                    mem_nxt.space = pr[0]; // odd pair selects data memory
                    mem_nxt.addr = x_ma;
                    mem_nxt.wdata = rf[b1h];
                    ld_nxt = x_ld;
                    lda_nxt = b1h;
                end
                if (first_r) begin
                    bad_nxt = x_bad;
                end
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    state_nxt = ldx_pkg::LDX_IDLE;
                    done_nxt = 1'b1;
                    ld_nxt = 1'b0;
                end
            end
        endcase
        busy_nxt = (state_nxt == ldx_pkg::LDX_EXEC);
    end

    // ----------------------------------------
    // register file write port select
    // ----------------------------------------
    logic rf_we;
    logic [7:0] rf_wa;
    logic [7:0] rf_wd;

    // external preload only while idle, so no contention
    always_comb begin
        rf_we = 1'b0;
        rf_wa = REG_WADDR;
        rf_wd = REG_WDATA;
        if (state_r == ldx_pkg::LDX_EXEC) begin
            if (cnt_r == 4'h1 && ld_r) begin
                rf_we = 1'b1;
                rf_wa = lda_r;
                rf_wd = MEM_RDATA;
            end else if (first_r && x_we) begin
                rf_we = 1'b1;
                rf_wa = x_wa;
                rf_wd = x_wd;
            end
        end else begin
            rf_we = REG_WE;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= ldx_pkg::LDX_IDLE;
            ins_r <= '0;
            mem_r <= '0;
            cnt_r <= 4'h0;
            first_r <= 1'b0;
            ld_r <= 1'b0;
            lda_r <= 8'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            bad_r <= 1'b0;
            flags_r <= `LDX_FLAGS_RST;
            dbg_r <= 8'h00;
        end else if (CE) begin
            state_r <= state_nxt;
            ins_r <= ins_nxt;
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            first_r <= first_nxt;
            ld_r <= ld_nxt;
            lda_r <= lda_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            bad_r <= bad_nxt;
            flags_r <= flags_nxt;
            dbg_r <= rf[DBG_ADDR];
        end
    end

    // array kept out of reset so it maps to plain memory
    always_ff @(posedge CLK) begin
        if (CE && !RST && rf_we) begin
            rf[rf_wa] <= rf_wd;
        end
    end

    assign MEM_REQ = mem_r;
    assign BUSY = busy_r;
    assign DONE = done_r;
    assign ILLEGAL = bad_r;
    assign FLAGS = flags_r;
    assign DBG_DATA = dbg_r;
endmodule : ldx_core

// ### rtl/ldx_map.svh
`ifndef LDX_MAP_SVH
`define LDX_MAP_SVH

// ----------------------------------------
// opcodes, low nibble of nibble-coded forms
// ----------------------------------------
`define LDX_LO_IMM 4'hc
`define LDX_LO_LDR 4'h8
`define LDX_LO_STR 4'h9
`define LDX_OP_IR_LD 8'hc7
`define LDX_OP_IR_ST 8'hd7
`define LDX_OP_RR 8'he4
`define LDX_OP_R_IR 8'he5
`define LDX_OP_R_IM 8'he6
`define LDX_OP_IR_IM 8'hd6
`define LDX_OP_IR_R 8'hf5
`define LDX_OP_X_LD 8'h87
`define LDX_OP_X_ST 8'h97
`define LDX_OP_BIT 8'h47
`define LDX_OP_MP_LD 8'hc3
`define LDX_OP_MP_ST 8'hd3
`define LDX_OP_XS_LD 8'he7
`define LDX_OP_XS_ST 8'hf7
`define LDX_OP_XL_LD 8'ha7
`define LDX_OP_XL_ST 8'hb7

// ----------------------------------------
// field values, reset values, cycle counts
// ----------------------------------------
`define LDX_PAIR_DA_PROG 4'h0
`define LDX_PAIR_DA_DATA 4'h1
`define LDX_FLAGS_RST 8'h00
`define LDX_CYC_SHORT 4'h4
`define LDX_CYC_LONG 4'h6
`define LDX_CYC_MEM_PTR 4'ha
`define LDX_CYC_MEM_XS 4'hc
`define LDX_CYC_MEM_XL 4'he
`define LDX_CYC_BAD 4'h1
`endif

// ### rtl/ldx_pkg.sv
// ----------------------------------------
// types shared by the load group core
// ----------------------------------------
package ldx_pkg;
    // opcode byte first, then operand bytes in fetch order
    typedef struct packed {
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] op;
    } ldx_instr_t;

    // memory request toward program or data memory
    typedef struct packed {
        logic rd;
        logic wr;
        logic space;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ldx_mem_t;

    typedef enum logic {LDX_IDLE, LDX_EXEC} ldx_state_t;
endpackage : ldx_pkg
